//--- common/spi_status_defs.vh
`ifndef SPI_STATUS_DEFS_VH
`define SPI_STATUS_DEFS_VH

// Register byte addresses
`define ADDR_STATUS   32'h4005_4000
`define ADDR_CONTROL  32'h4005_4010
`define ADDR_IEN      32'h4005_4014
`define ADDR_DMA      32'h4005_401C
`define ADDR_FLOW     32'h4005_4028
`define ADDR_MASK     32'h4005_4038

// Status bit positions
`define ST_RDY        15
`define ST_FALL       14
`define ST_RISE       13
`define ST_ERR        12
`define ST_CS         11
`define ST_OVR        7
`define ST_RXEV       6
`define ST_TXEV       5

// Status reset, sticky positions, readable positions
`define STATUS_RESET  16'h0800
`define STATUS_W1C    16'hF0E0
`define STATUS_RDMASK 16'hF8E0

// Control bit positions and writable bits
`define CTL_EN        0
`define CTL_MASTER    1
`define CTL_TIM       6
`define CTL_CONT      11
`define CTL_FLUSH     12
`define CTL_MASK      16'h1843

// Interrupt enable setup bits
`define IEN_CSEDGE    8
`define IEN_RDY       11
`define IEN_MASK      16'h0900

// Flow control setup field and polarity
`define FLOW_MODE_HI  1
`define FLOW_MODE_LO  0
`define FLOW_POL      4
`define FLOW_MASK     16'h0013
`define FLOW_RDY_PIN  2'h2
`define FLOW_RDY_MISO 2'h3

// DMA enable
`define DMA_EN        0
`define DMA_MASK      16'h0001

// Serial bits per byte
`define BYTE_BITS     4'h8

`endif

//--- dv/spi_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// External serial master and ready sources
module spi_far_end (
  output var logic csN,
  output var logic sclk,
  output var logic miso,
  output var logic drdy
);
  // Deselected, clock parked low between frames
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    miso = 1'b0;
    drdy = 1'b0;
  end
  // Frame of n pulses at 48 ns; under 8 aborts mid-byte
  task automatic frame(input int n);
    // Start off the bench clock's edges so no pin races mclk
    #1.25;
    csN = 1'b0;
    #30;
    repeat (n) begin
      sclk = 1'b1;
      #24;
      sclk = 1'b0;
      #24;
    end
    #30;
    csN = 1'b1;
  endtask
  // One pulse, rise then fall, on a ready source; slow enough for the sync
  task automatic rdyEdge(input logic src);
    // Start off the bench clock's edges so no pin races mclk
    #1.25;
    if (src)
      miso = 1'b1;
    else
      drdy = 1'b1;
    #30;
    miso = 1'b0;
    drdy = 1'b0;
    #30;
  endtask
endmodule // spi_far_end
`default_nettype wire

//--- dv/spi_status_flags_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "spi_status_defs.vh"
// Bus-side and select-level checks on the status block
module spi_status_flags_props (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        chipSelectLineN,
  input wire logic        rxLoad,
  input wire logic        rxFifoFull
);
  // Decoded register window
  wire mapped = paddr == `ADDR_STATUS || paddr == `ADDR_CONTROL ||
    paddr == `ADDR_IEN || paddr == `ADDR_DMA || paddr == `ADDR_FLOW ||
    paddr == `ADDR_MASK;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Read setup then access on any address
  sequence rdAny;
    psel && !penable && !pwrite && ce ##1 psel && penable;
  endsequence
  // Same, on the status word
  sequence rdStat;
    paddr == `ADDR_STATUS ##0 rdAny;
  endsequence
  unmapped_err_a: assert property (
    psel && penable && ce && !mapped |-> pslverr) else $error("no slverr");
  mapped_ok_a: assert property (
    psel && penable && mapped |-> !pslverr) else $error("bad slverr");
  hole_zero_a: assert property (
    !mapped ##0 rdAny |-> prdata == 32'h0000_0000) else $error("hole");
  upper_zero_a: assert property (
    mapped ##0 rdAny |-> prdata[31:16] == 16'h0000) else $error("upper");
  reserved_zero_a: assert property (
    rdStat |-> (prdata & 32'hFFFF_071F) == 32'h0000_0000)
    else $error("reserved bits");
  overflow_set_a: assert property (
    rxLoad && rxFifoFull && ce ##1 !psel ##1 rdStat |-> prdata[7])
    else $error("overflow lost");
  select_high_a: assert property (
    (chipSelectLineN && ce) [*4] ##0 rdStat |-> prdata[11])
    else $error("level high");
  select_low_a: assert property (
    (!chipSelectLineN && ce) [*4] ##0 rdStat |-> !prdata[11])
    else $error("level low");
endmodule // spi_status_flags_props
bind spi_status_flags spi_status_flags_props u_props (.mclk(mclk),
  .rstn(rstn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .rxLoad(rxLoad),
  .chipSelectLineN(chipSelectLineN), .rxFifoFull(rxFifoFull));
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "spi_status_defs.vh"
// Register-level test of the status flags
module testbench;
  localparam logic [31:0] ST = `ADDR_STATUS;
  localparam logic [31:0] CT = `ADDR_CONTROL;
  logic        mclk, rstn, ce, psel, penable, pwrite;
  logic [31:0] paddr, pwdata, q, e;
  logic [3:0]  ev;     // Load, full, rx count, tx count
  wire  [31:0] prdata;
  wire         pready, pslverr, irq, csN, sclk, miso, drdy, pe, mm, de;
  int          n_fail, total_checks, cyc;
  spi_status_flags i_dut (.mclk(mclk), .rstn(rstn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chipSelectLineN(csN), .dataReadyInput(drdy), .slaveReadyLine(miso),
    .serialClock(sclk), .rxLoad(ev[3]), .rxFifoFull(ev[2]),
    .rxCountDone(ev[1]), .txCountDone(ev[0]), .irq(irq),
    .portEnable(pe), .masterMode(mm), .dmaEnable(de));
  spi_far_end far (.csN(csN), .sclk(sclk), .miso(miso), .drdy(drdy));
  // 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Hang guard, far above the expected run
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, x);
    total_checks++;
    if (s !== x) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask
  // APB transfer; request held until pready is seen
  task automatic wr(input logic [31:0] a, d, input logic w = 1'b1);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, x, input string nm);
    wr(a, 32'h0000_0000, 1'b0);
    chk(nm, q, x);
  endtask
  // Irq looked at mid-cycle, after register updates land
  task automatic ci(input logic x);
    @(negedge mclk);
    chk("irq", 32'(irq), 32'(x));
  endtask
  task automatic pulse(input logic [3:0] v);
    @(posedge mclk);
    ev <= v;
    @(posedge mclk);
    ev <= 4'h0;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    {rstn, psel, penable, pwrite, ev} = 8'h00;
    ce = 1'b1;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    rd(ST, 32'h0000_0800, "reset");
    rd(32'h4005_4004, 32'h0000_0000, "hole");
    wr(`ADDR_MASK, 32'h0000_F0E0);
    // Master mode: a short frame is no abort
    wr(CT, 32'h0000_0003);
    @(negedge mclk);
    chk("mode", 32'({mm, pe}), 32'h0000_0003);
    far.frame(3);
    repeat (5) @(posedge mclk);
    rd(ST, 32'h0000_0800, "master");
    wr(CT, 32'h0000_0801);
    @(negedge mclk);
    chk("mode", 32'({mm, pe}), 32'h0000_0001);
    // Edge flags only while the edge enable is set
    for (int i = 0; i < 2; i++) begin
      wr(`ADDR_IEN, i ? 32'h0000_0000 : 32'h0000_0100);
      e = i ? 32'h0000_0800 : 32'h0000_6800;
      fork
        far.frame(8);
        begin
          #100;
          rd(ST, e & 32'h0000_4000, "low");
        end
      join
      repeat (5) @(posedge mclk);
      rd(ST, e, "frame");
      ci(i == 0);
      wr(ST, 32'h0000_0F1F);
      rd(ST, e, "keep");
      wr(ST, 32'h0000_F0E0);
      rd(ST, 32'h0000_0800, "clear");
    end
    far.frame(3);
    repeat (5) @(posedge mclk);
    rd(ST, 32'h0000_1800, "abort");
    ci(1'b1);
    wr(CT, 32'h0000_0800);
    @(negedge mclk);
    chk("enable", 32'(pe), 32'h0000_0000);
    wr(CT, 32'h0000_0801);
    wr(ST, 32'h0000_1000);
    ci(1'b0);
    // Each ready source counts only in its own mode
    for (int m = 0; m < 4; m++) begin
      wr(`ADDR_FLOW, 32'(m));
      for (int s = 0; s < 2; s++) begin
        far.rdyEdge(s[0]);
        e = (m == s + 2) ? 32'h0000_8800 : 32'h0000_0800;
        rd(ST, e, "ready");
        wr(ST, 32'h0000_8000);
      end
    end
    // Falling polarity: the rising half of a pulse sets nothing
    wr(`ADDR_FLOW, 32'h0000_0012);
    fork
      far.rdyEdge(1'b0);
      begin
        #22;
        rd(ST, 32'h0000_0800, "rise ignored");
      end
    join
    rd(ST, 32'h0000_8800, "fall seen");
    wr(ST, 32'h0000_8000);
    wr(`ADDR_IEN, 32'h0000_0800);
    wr(`ADDR_FLOW, 32'h0000_0002);
    far.rdyEdge(1'b0);
    ci(1'b1);
    rd(ST, 32'h0000_8800, "ready irq");
    rd(ST, 32'h0000_0800, "read clear");
    pulse(4'h8);
    rd(ST, 32'h0000_0800, "load");
    pulse(4'hC);
    rd(ST, 32'h0000_0880, "overflow");
    ci(1'b1);
    wr(CT, 32'h0000_1801);
    ci(1'b0);
    wr(ST, 32'h0000_0080);
    // Count events by initiate mode, none under DMA
    for (int t = 0; t < 3; t++) begin
      wr(CT, t == 1 ? 32'h0000_0841 : 32'h0000_0801);
      wr(`ADDR_DMA, 32'(t == 2));
      @(negedge mclk);
      chk("dma", 32'(de), 32'(t == 2));
      pulse(4'h3);
      e = t == 2 ? 32'h0000_0800 : t ? 32'h0000_0820 : 32'h0000_0840;
      rd(ST, e, "count");
      wr(ST, 32'h0000_0060);
    end
    test_done();
  end
endmodule // testbench
`default_nettype wire

//--- logic/spi_status_flags.v
`timescale 1ns/1ps
`default_nettype none
`include "spi_status_defs.vh"

// Function
// - Mode 2: data-ready edge sets ready flag
// - Mode 3: slave data-in edge sets ready
// - Other modes hold ready flag at zero
// - Enable bit 11: ready interrupts, read clears
// - Slave continuous, enable bit 8: select fall sets bit 14
// - Slave continuous, enable bit 8: select rise sets bit 13
// - Slave mode: select abort mid-byte sets error flag
// - Bit 11 shows synchronised select level
// - Overflow flag; interrupt unless flush set
// - Initiate mode clear: receive count sets flag
// - Initiate mode set: transmit count sets flag
// - No receive/transmit flags in DMA mode
// - Writing one clears sticky flags
module spi_status_flags #(
  parameter BYTE_BITS = `BYTE_BITS
) (
  input  wire        mclk,
  input  wire        rstn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        chipSelectLineN,
  input  wire        dataReadyInput,
  input  wire        slaveReadyLine,
  input  wire        serialClock,
  input  wire        rxLoad,
  input  wire        rxFifoFull,
  input  wire        rxCountDone,
  input  wire        txCountDone,
  output wire        irq,
  output wire        portEnable,
  output wire        masterMode,
  output wire        dmaEnable
);

  // Software visible registers
  reg  [15:0] status_q;   // Sticky flags, level bit lives apart
  reg  [15:0] control_q;  // Port control
  reg  [15:0] ienSetup_q; // Interrupt enable setup
  reg  [15:0] flowSetup_q;// Flow control setup
  reg  [15:0] dma_q;      // DMA enable
  reg  [15:0] mask_q;     // Interrupt mask, status layout
  reg  [15:0] status_d;   // Next sticky flags

  // Serial-side bit count within a byte
  reg  [3:0]  bitCount_q;

  // Synchronised link signals
  wire        csLevel;
  wire        select_rise_flag;
  wire        select_fall_flag;
  wire        drdyRise;
  wire        drdyFall;
  wire        misoRise;
  wire        misoFall;
  wire        sclkRise;

  // Bus decode
  wire        setup;
  wire        access;
  wire        wrAccess;
  wire        rdSetup;
  wire        hitStatus;
  wire        hitControl;
  wire        hitIen;
  wire        hitDma;
  wire        hitFlow;
  wire        hitMask;
  wire        mapped;

  // Configuration decode
  wire [1:0]  flowMode;
  wire        rdyPolFall;
  wire        slaveMode;
  wire        contMode;
  wire        csEdgeEn;
  wire        rdyIrqEn;
  wire        flushOn;
  wire        timSet;

  // Events
  wire        rdyEvent;
  wire        fallEvent;
  wire        riseEvent;
  wire        errEvent;
  wire        ovrEvent;
  wire        rxEvent;
  wire        txEvent;
  wire [15:0] setVec;
  wire [15:0] clrVec;
  wire [15:0] irqCause;
  wire [15:0] statusView;

  // Chip select idles high, so its synchroniser resets high
  spi_sync_edge #(
    .RESET_VAL (1'b1)
  ) u_syncCs (
    .mclk  (mclk),
    .rstn  (rstn),
    .ce    (ce),
    .pinIn (chipSelectLineN),
    .level (csLevel),
    .rise  (select_rise_flag),
    .fall  (select_fall_flag)
  );

  // Data-ready pin from the slave
  spi_sync_edge #(
    .RESET_VAL (1'b0)
  ) u_syncDrdy (
    .mclk  (mclk),
    .rstn  (rstn),
    .ce    (ce),
    .pinIn (dataReadyInput),
    .level (),
    .rise  (drdyRise),
    .fall  (drdyFall)
  );

  // Serial data in, used as ready line in mode 3
  spi_sync_edge #(
    .RESET_VAL (1'b0)
  ) u_syncMiso (
    .mclk  (mclk),
    .rstn  (rstn),
    .ce    (ce),
    .pinIn (slaveReadyLine),
    .level (),
    .rise  (misoRise),
    .fall  (misoFall)
  );

  // Every pin has the same two-stage latency, so clock and
  // select edges keep their order after synchronisation
  // Serial clock; only its rising edges are counted
  spi_sync_edge #(
    .RESET_VAL (1'b0)
  ) u_syncSclk (
    .mclk  (mclk),
    .rstn  (rstn),
    .ce    (ce),
    .pinIn (serialClock),
    .level (),
    .rise  (sclkRise),
    .fall  ()
  );

  // pready follows ce: no wait states are added, but a frozen
  // block must not let the master finish a transfer
  // APB phases; a frozen block holds the master off
  assign setup    = psel & ~penable;
  assign access   = psel & penable & ce;
  assign wrAccess = access & pwrite;
  assign rdSetup  = setup & ~pwrite & ce;
  assign pready   = ce;

  // Full address compare; the block answers only here
  assign hitStatus  = (paddr == `ADDR_STATUS);
  assign hitControl = (paddr == `ADDR_CONTROL);
  assign hitIen     = (paddr == `ADDR_IEN);
  assign hitDma     = (paddr == `ADDR_DMA);
  assign hitFlow    = (paddr == `ADDR_FLOW);
  assign hitMask    = (paddr == `ADDR_MASK);
  assign mapped     = hitStatus | hitControl | hitIen |
                      hitDma | hitFlow | hitMask;

  // Unmapped address: error in the access phase
  assign pslverr = access & ~mapped;

  // Configuration fields
  assign flowMode   = flowSetup_q[`FLOW_MODE_HI:`FLOW_MODE_LO];
  assign rdyPolFall = flowSetup_q[`FLOW_POL];
  assign slaveMode  = control_q[`CTL_EN] & ~control_q[`CTL_MASTER];
  assign contMode   = control_q[`CTL_CONT];
  assign csEdgeEn   = ienSetup_q[`IEN_CSEDGE];
  assign rdyIrqEn   = ienSetup_q[`IEN_RDY];
  assign flushOn    = control_q[`CTL_FLUSH];
  assign timSet     = control_q[`CTL_TIM];

  assign portEnable = control_q[`CTL_EN];
  assign masterMode = control_q[`CTL_MASTER];
  assign dmaEnable  = dma_q[`DMA_EN];

  // Ready edge source depends on flow mode; polarity picks edge
  assign rdyEvent =
    (flowMode == `FLOW_RDY_PIN)  ? (rdyPolFall ? drdyFall
                                               : drdyRise) :
    (flowMode == `FLOW_RDY_MISO) ? (rdyPolFall ? misoFall
                                               : misoRise) :
    1'b0;

  // Frame edges only in slave continuous mode with enable bit 8
  assign fallEvent = slaveMode & contMode & csEdgeEn & select_fall_flag;
  assign riseEvent = slaveMode & contMode & csEdgeEn & select_rise_flag;

  // Select released with a partial byte shifted in
  // The count still holds the partial byte in the rise cycle,
  // because its own clear lands one edge later
  assign errEvent = slaveMode & select_rise_flag &
                    (bitCount_q != 4'h0);

  // Byte loaded into an already full receive FIFO
  assign ovrEvent = rxLoad & rxFifoFull;

  // Count events are suppressed under DMA
  assign rxEvent = rxCountDone & ~timSet &
                   ~dma_q[`DMA_EN];
  assign txEvent = txCountDone & timSet &
                   ~dma_q[`DMA_EN];

  // Gather set requests in status layout
  assign setVec = {rdyEvent, fallEvent, riseEvent, errEvent,
                   4'h0, ovrEvent, rxEvent, txEvent, 5'h00};

  // Write-one clears only sticky positions; a ready read
  // returned as one clears it when its interrupt is enabled
  assign clrVec =
    ((wrAccess & hitStatus) ? (pwdata[15:0] & `STATUS_W1C)
                            : 16'h0000) |
    {(access & ~pwrite & hitStatus & rdyIrqEn &
      prdata[`ST_RDY]), 15'h0000};

  // Next sticky state: a set in the same cycle beats a clear
  always @* begin
    status_d = ((status_q & ~clrVec) | setVec) & `STATUS_W1C;
    if (flowMode != `FLOW_RDY_PIN && flowMode != `FLOW_RDY_MISO) begin
      status_d[`ST_RDY] = 1'b0;
    end
  end

  // Sticky flags
  // Only sticky positions are stored; the level bit joins on read
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      status_q <= `STATUS_RESET & `STATUS_W1C;
    end else if (ce) begin
      status_q <= status_d;
    end
  end

  // Bits of a byte seen while selected; cleared on select edges
  // so a fresh frame starts at zero
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bitCount_q <= 4'h0;
    end else if (ce) begin
      if (select_fall_flag || select_rise_flag || csLevel) begin
        bitCount_q <= 4'h0;
      end else if (sclkRise) begin
        if (bitCount_q == BYTE_BITS - 4'h1) begin
          bitCount_q <= 4'h0; // Byte complete
        end else begin
          bitCount_q <= bitCount_q + 4'h1;
        end
      end
    end
  end

  // Control registers; only defined bits store
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      control_q   <= 16'h0000;
      ienSetup_q  <= 16'h0000;
      flowSetup_q <= 16'h0000;
      dma_q       <= 16'h0000;
      mask_q      <= 16'h0000;
    end else if (ce && wrAccess) begin
      if (hitControl) begin
        control_q <= pwdata[15:0] & `CTL_MASK;
      end
      if (hitIen) begin
        ienSetup_q <= pwdata[15:0] & `IEN_MASK;
      end
      if (hitFlow) begin
        flowSetup_q <= pwdata[15:0] & `FLOW_MASK;
      end
      if (hitDma) begin
        dma_q <= pwdata[15:0] & `DMA_MASK;
      end
      if (hitMask) begin
        mask_q <= pwdata[15:0] & `STATUS_W1C;
      end
    end
  end

  // Status as read: sticky flags plus live select level
  assign statusView = status_q |
                      {4'h0, csLevel, 11'h000};

  // Capturing early keeps the read path one register deep; the
  // cost is that a flag set in the access phase shows next read
  // Read data captured in the setup phase, held for access;
  // reserved and upper bits read as zero
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (rdSetup) begin
      if (hitStatus) begin
        prdata <= {16'h0000, statusView & `STATUS_RDMASK};
      end else if (hitControl) begin
        prdata <= {16'h0000, control_q};
      end else if (hitIen) begin
        prdata <= {16'h0000, ienSetup_q};
      end else if (hitFlow) begin
        prdata <= {16'h0000, flowSetup_q};
      end else if (hitDma) begin
        prdata <= {16'h0000, dma_q};
      end else if (hitMask) begin
        prdata <= {16'h0000, mask_q};
      end else begin
        prdata <= 32'h0000_0000; // Unmapped
      end
    end
  end

  // Which flags may interrupt: ready needs bit 11, overflow
  // is silenced by flush, frame start never interrupts
  assign irqCause = {rdyIrqEn, 1'b0, 1'b1, 1'b1,
                     4'h0, ~flushOn, 1'b1, 1'b1,
                     5'h00};

  // Level interrupt while any unmasked, enabled flag is set
  // Built from registers only, so bus traffic cannot glitch it
  assign irq = |(status_q & mask_q & irqCause);

endmodule // spi_status_flags

`default_nettype wire

//--- logic/spi_sync_edge.v
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser with edge detection on the settled copy
module spi_sync_edge #(
  parameter RESET_VAL = 1'b0
) (
  input  wire mclk,
  input  wire rstn,
  input  wire ce,
  input  wire pinIn,
  output wire level,
  output wire rise,
  output wire fall
);

  reg meta_q;   // First stage, read only by the second
  reg sync_q;   // Settled level
  reg prev_q;   // Last settled level for edges

  // Edges come from settled stages only, so each pin edge
  // gives exactly one pulse
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
      prev_q <= RESET_VAL;
    end else if (ce) begin
      meta_q <= pinIn;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~prev_q;
  assign fall  = ~sync_q & prev_q;

endmodule // spi_sync_edge

`default_nettype wire
